// >>> sim/adcsq_cell_model.sv
// Behavioural analog conversion cell: one result pulse for each convert request.
// Assumes cell_convert is a one-cycle pulse on mclk, given only while the cell is powered.
`timescale 1ns/100ps
module adcsq_cell_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cell_power_on,
  input wire logic cell_convert,
  input wire logic [9:0] next_data,
  input wire logic [5:0] lag,
  output logic cell_done = 1'b0,
  output logic [9:0] cell_data = 10'h3ff
);
  int wait_r = 0; // Cycles until the result, 0 when idle
  logic [9:0] last_r = 10'h000; // Last value really driven
  // Countdown of ten master clocks plus a chosen lag, so prompt and slow answers are tried
  always @(posedge mclk) begin
    cell_done <= 1'b0;
    // Outside the result cycle the lines are released: show the inverse, never a stale match
    cell_data <= ~last_r;
    if (!rst_b) begin
      wait_r <= 0;
    end else if (cell_convert && cell_power_on) begin
      wait_r <= 10 + lag;
    end else if (wait_r == 1) begin
      wait_r <= 0;
      cell_done <= 1'b1;
      cell_data <= next_data;
      last_r <= next_data;
    end else if (wait_r > 1) begin
      wait_r <= wait_r - 1;
    end
  end
endmodule : adcsq_cell_model

// >>> sim/tb_top.sv
// Self-checking bench for the converter sequencer with a flag and result model.
// Assumes the cell model file is compiled before and the register header is on the path.
`timescale 1ns/100ps
`include "adcsq_regs.svh"
module tb_top;
  logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ext = 1'b0, dma_take = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [2:0] tw = 3'h0; // Timer trigger levels
  logic [9:0] next_data = 10'h155, cell_data; // Value the cell returns next
  logic [5:0] lag = 6'h00;
  logic power, convert, eight, sampling, done, dma_req;
  logic [2:0] chan;
  int mismatches = 0, checks = 0, seed = 70342;
  int n_conv = 0, n_done = 0, samp = 0, cur_ch = 0, last_ch = 0, m_dcnt = 0;
  logic exp_dreq = 1'b0; // DMA request expected at the next edge
  int chq[$]; // Channels expected in order of conversion
  logic [7:0] m_en, m_done, m_ovr; // Model of enables and flags
  logic m_rdy, m_govr, m_dma_count_end_flag, m_full, m_eight;
  int m_div, m_sht;
  logic [9:0] m_res[8];
  always #2 mclk = ~mclk;
  adcsq_top u_adcsq_top (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_waveform_output(tw), .external_trigger_pin(ext), .dma_word_taken(dma_take),
    .cell_power_on(power), .cell_convert(convert), .cell_channel(chan),
    .cell_eight_bit(eight), .cell_sampling(sampling), .cell_done(done),
    .cell_data(cell_data), .dma_request(dma_req));
  adcsq_cell_model u_adcsq_cell_model (.mclk(mclk), .rst_b(rst_b), .cell_power_on(power),
    .cell_convert(convert), .next_data(next_data), .lag(lag), .cell_done(done),
    .cell_data(cell_data));
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Bus cycles: one strobe cycle each, read data taken in the following cycle
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e, input string w);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 cmp(w, e, reg_rdata);
  endtask : rdc
  // Status read; overrun flags clear in the model as they should in the block
  task flags;
    rdc(8'h1c, {12'h000, m_full, m_dma_count_end_flag, m_govr, m_rdy, m_ovr, m_done}, "flags");
    m_ovr = 8'h00;
    m_govr = 1'b0;
  endtask : flags
  task setw(input logic [31:0] v);
    wr(`ADCSQ_OFF_SETUP, v);
    m_div = v[13:8];
    m_sht = v[27:24];
    m_eight = v[4];
  endtask : setw
  task mreset;
    {m_en, m_done, m_ovr, m_rdy, m_govr, m_eight, m_div, m_sht} = '0;
    {m_dma_count_end_flag, m_full} = 2'b11;
    foreach (m_res[i]) m_res[i] = 10'h000;
  endtask : mreset
  task results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // Start from software (8), a timer bit (0-2), the pin (6) or all pins (9)
  task go(input int src, input bit fire);
    int base, tgt, i;
    base = n_conv;
    tgt = n_done;
    if (fire) for (i = 0; i < 8; i++) if (m_en[i]) begin
      chq.push_back(i);
      tgt++;
    end
    if (src == 8) wr(`ADCSQ_OFF_COMMAND, 32'h2);
    else begin
      @(posedge mclk);
      if (src < 3) tw[src] <= 1'b1;
      else if (src == 6) ext <= 1'b1;
      else {tw, ext} <= 4'hf;
      // Held for several cycles so the synchronisers see the edge
      repeat (8) @(posedge mclk);
      {tw, ext} <= 4'h0;
    end
    i = 0;
    while (fire && n_done != tgt) begin
      @(posedge mclk);
      i++;
      if (i > 5000) begin
        cmp("sequence timeout", 0, 1);
        results;
      end
    end
    repeat (fire ? 30 : 150) @(posedge mclk);
    if (!fire) cmp("conversions", base, n_conv);
  endtask : go
  // Monitor of the cell side; the model follows each result as the flags should
  always @(posedge mclk) begin
    if (rst_b) cmp("dma_request", exp_dreq, dma_req);
    exp_dreq = done && m_dcnt != 0;
    if (convert) begin
      n_conv++;
      if (chq.size() == 0) cmp("unexpected convert", 1, 0);
      else begin
        cur_ch = chq.pop_front();
        cmp("cell_channel", cur_ch, chan);
        cmp("cell_eight_bit", m_eight, eight);
      end
    end
    if (done) begin
      if (m_done[cur_ch]) m_ovr[cur_ch] = 1'b1;
      if (m_rdy) m_govr = 1'b1;
      m_done[cur_ch] = 1'b1;
      m_rdy = 1'b1;
      last_ch = cur_ch;
      m_res[cur_ch] = m_eight ? {2'b00, cell_data[9:2]} : cell_data;
      n_done++;
      next_data <= 10'($random(seed));
    end
    if (sampling) samp++;
    else if (samp != 0) begin
      cmp("sample length", (m_sht + 1) * 2 * (m_div + 1), samp);
      samp = 0;
    end
  end
  initial begin
    logic [31:0] v, e, s;
    int i, c;
    static int tcode[5] = '{0, 1, 2, 6, 3};
    mreset;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rdc(8'h04, 32'h0, "setup");
    rdc(8'h18, 32'h0, "channel state");
    flags;
    rdc(8'h20, 32'h0, "latest");
    rdc(8'h2c, 32'h0, "irq mask");
    for (i = 0; i < 8; i++) rdc(8'(8'h30 + 4 * i), 32'h0, "result");
    v = $random(seed);
    wr(8'h24, v);
    wr(8'h28, v & 32'h0000ff00);
    rdc(8'h2c, v & 32'h000f00ff, "irq mask");
    s = $random(seed);
    setw(s);
    rdc(8'h04, s & `ADCSQ_SETUP_MASK, "setup");
    v = $random(seed);
    e = $random(seed);
    wr(8'h10, v);
    wr(8'h14, e); // Idle, so no conversion is disturbed
    wr(8'h08, 32'hffffffff); // Reserved offset must ignore this
    rdc(8'h18, {24'h0, v[7:0] & ~e[7:0]}, "channel state");
    rdc(8'h08, 32'h0, "reserved");
    wr(`ADCSQ_OFF_COMMAND, 32'h0);
    repeat (30) @(posedge mclk);
    cmp("conversions", 0, n_conv);
    rdc(8'h04, s & `ADCSQ_SETUP_MASK, "setup");
    wr(`ADCSQ_OFF_COMMAND, 32'h1);
    repeat (3) @(posedge mclk);
    mreset;
    rdc(8'h04, 32'h0, "setup");
    rdc(8'h18, 32'h0, "channel state");
    setw(32'h02000100);
    m_en = 8'($random(seed)) | 8'h01;
    wr(8'h10, {24'h0, m_en});
    go(8, 1);
    #1 cmp("power normal", 1, power);
    flags;
    for (i = 0; i < 8; i++) begin
      rdc(8'(8'h30 + 4 * i), {22'h0, m_res[i]}, "result");
      m_done[i] = 1'b0;
    end
    flags;
    rdc(8'h20, {22'h0, m_res[last_ch]}, "latest");
    m_rdy = 1'b0;
    flags;
    lag = 6'd20;
    go(8, 1);
    go(8, 1);
    flags;
    flags;
    setw(32'h02000130);
    go(8, 1);
    rdc(8'(8'h30 + 4 * last_ch), {22'h0, m_res[last_ch]}, "result 8-bit");
    m_done[last_ch] = 1'b0;
    #1 cmp("power sleep", 0, power);
    lag = 6'd0;
    setw(32'h0200010c);
    go(9, 0);
    for (i = 0; i < 5; i++) begin
      c = tcode[i];
      setw(32'h02000101 | 32'(c << 1));
      go(c == 3 ? 9 : c, c != 3);
    end
    wr(8'h54, 32'h0);
    wr(8'h50, 32'h2);
    m_dcnt = 2;
    {m_dma_count_end_flag, m_full} = 2'b00;
    flags;
    go(8, 1);
    repeat (2) begin
      @(posedge mclk);
      dma_take <= 1'b1;
      @(posedge mclk);
      dma_take <= 1'b0;
    end
    m_dcnt = 0;
    {m_dma_count_end_flag, m_full} = 2'b11;
    flags;
    results;
  end
endmodule : tb_top

// >>> src/adcsq_clkdiv.sv
// Converter clock tick generator: a one-cycle pulse every 2*(divider+1) master clocks.
// Assumes a synchronous active-low reset on the master clock.
`timescale 1ns/100ps
`include "adcsq_regs.svh"
module adcsq_clkdiv
  import adcsq_pkg::*;
#(
  parameter int DIV_W = 6
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [DIV_W-1:0] divider,
  output logic tick
);
  logic [DIV_W:0] cnt_r; // Master clocks in the current converter period
  wire [DIV_W:0] last_w = {divider, 1'b1}; // 2*(divider+1)-1
  wire wrap_w = (cnt_r >= last_w);
  // Period counter; the >= compare recovers if divider shrinks mid-period
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= wrap_w ? '0 : cnt_r + 1'b1; // [R8]
      tick <= wrap_w;
    end
  end
endmodule : adcsq_clkdiv

// >>> src/adcsq_pkg.sv
// Types shared by the converter sequencer modules.
// Assumes adcsq_regs.svh is on the include path.
package adcsq_pkg;
  // Operating setup fields as software sees them
  typedef struct packed {
    logic [3:0] sample_hold_time;
    logic [4:0] startup_time;
    logic [5:0] conv_clock_divider;
    logic sleep_select;
    logic eight_bit_select;
    logic [2:0] hw_trigger_select;
    logic hw_trigger_enable;
  } adcsq_setup_t;
  // Result handed back by the analog cell
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [9:0] data;
  } adcsq_result_t;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ADCSQ_IDLE = 5'h01,
    ADCSQ_WAKE = 5'h02,
    ADCSQ_SAMPLE = 5'h04,
    ADCSQ_CONVERT = 5'h08,
    ADCSQ_NEXT = 5'h10
  } adcsq_state_t;
endpackage : adcsq_pkg

// >>> src/adcsq_regs.svh
// Register offsets, field positions, reset values and timing constants of the converter sequencer.
// Included by the design modules and the bench; definitions only.
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH
`define ADCSQ_OFF_COMMAND 8'h00
`define ADCSQ_OFF_SETUP 8'h04
`define ADCSQ_OFF_CH_EN 8'h10
`define ADCSQ_OFF_CH_DIS 8'h14
`define ADCSQ_OFF_CH_STATE 8'h18
`define ADCSQ_OFF_FLAGS 8'h1c
`define ADCSQ_OFF_LATEST 8'h20
`define ADCSQ_OFF_IRQ_UNMASK 8'h24
`define ADCSQ_OFF_IRQ_REMASK 8'h28
`define ADCSQ_OFF_IRQ_STATE 8'h2c
`define ADCSQ_OFF_RESULT0 8'h30
`define ADCSQ_OFF_RESULT7 8'h4c
`define ADCSQ_OFF_DMA_CNT 8'h50
`define ADCSQ_OFF_DMA_NEXT 8'h54
`define ADCSQ_BIT_SOFT_RESET 0
`define ADCSQ_BIT_START 1
`define ADCSQ_BIT_TRIG_EN 0
`define ADCSQ_BIT_EIGHT 4
`define ADCSQ_BIT_SLEEP 5
`define ADCSQ_SETUP_MASK 32'h0f1f3f3f
`define ADCSQ_FLAGS_RESET 32'h000c0000
`define ADCSQ_SEL_TIMER0 3'h0
`define ADCSQ_SEL_TIMER1 3'h1
`define ADCSQ_SEL_TIMER2 3'h2
`define ADCSQ_SEL_EXT 3'h6
`define ADCSQ_STARTUP_MULT 4
`define ADCSQ_CONV_CYCLES 4'ha
`endif

// >>> src/adcsq_top.sv
// Converter sequencer: register file, trigger handling, sequencer and status flags.
// Assumes a plain register port on mclk and an analog cell that answers each conversion
// request with one result pulse; trigger pins are asynchronous.
// Behaviour
// R1: Command bit 0 resets the whole block
// R2: Command bit 1 starts a sequence
// R3: Trigger enable low ignores hardware triggers
// R4: Trigger enable high accepts the selected trigger
// R5: Select codes 0-2 timers, 6 external pin
// R6: Resolution bit chooses ten or eight bits
// R7: Sleep bit powers cell down between sequences
// R8: Converter clock is master over 2*(div+1)
// R9: Startup waits 8*(startup+1) converter clocks
// R10: Sampling lasts sample-hold+1 converter clocks
// R11: Channel enable write sets channels
// R12: Channel disable write clears channels
// R13: Software avoids disabling channels mid-conversion
// R14: Channel state shows enables, reset all off
// R15: Done flag means enabled and converted
// R16: Channel overrun flags since last status read
// R17: Ready flag since last latest-result read
// R18: Global overrun since last status read
// R19: DMA count end since last counter write
// R20: Buffers full when both counters zero
// R21: Per-channel results at 0x30 to 0x4c
// R22: Setup register field layout
// R23: Result reads clear done and ready flags
// R24: Status read clears overrun flags
// R25: Rising edge of selected trigger starts
// R26: Unmask write sets interrupt mask bits
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "adcsq_regs.svh"
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int NCH = 8,
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] timer_waveform_output,
  input wire logic external_trigger_pin,
  input wire logic dma_word_taken,
  output logic cell_power_on,
  output logic cell_convert,
  output logic [2:0] cell_channel,
  output logic cell_eight_bit,
  output logic cell_sampling,
  input wire logic cell_done,
  input wire logic [9:0] cell_data,
  output logic dma_request
);
  // Register writes and reads decoded as named wires
  wire wr_cmd = reg_wr && reg_addr == `ADCSQ_OFF_COMMAND;
  wire soft_rst = wr_cmd && reg_wdata[`ADCSQ_BIT_SOFT_RESET]; // [R1]
  logic soft_rst_r; // Pending software reset
  wire blk_rst_b = rst_b && !soft_rst_r; // Soft reset acts one cycle after the write
  wire sw_start = wr_cmd && reg_wdata[`ADCSQ_BIT_START]; // [R2]
  wire wr_setup = reg_wr && reg_addr == `ADCSQ_OFF_SETUP;
  wire wr_chen = reg_wr && reg_addr == `ADCSQ_OFF_CH_EN;
  wire wr_chdis = reg_wr && reg_addr == `ADCSQ_OFF_CH_DIS;
  wire wr_unmask = reg_wr && reg_addr == `ADCSQ_OFF_IRQ_UNMASK;
  wire wr_remask = reg_wr && reg_addr == `ADCSQ_OFF_IRQ_REMASK;
  wire wr_dcnt = reg_wr && reg_addr == `ADCSQ_OFF_DMA_CNT;
  wire wr_dnext = reg_wr && reg_addr == `ADCSQ_OFF_DMA_NEXT;
  wire rd_flags = reg_rd && reg_addr == `ADCSQ_OFF_FLAGS;
  wire rd_latest = reg_rd && reg_addr == `ADCSQ_OFF_LATEST;
  wire rd_res = reg_rd && reg_addr >= `ADCSQ_OFF_RESULT0 && reg_addr <= `ADCSQ_OFF_RESULT7;
  wire [7:0] res_off = reg_addr - `ADCSQ_OFF_RESULT0;
  wire [2:0] res_idx = res_off[4:2];

  logic warm_r; // Cell already powered when the sequence began
  adcsq_setup_t setup_r; // Operating setup register [R22]
  logic [NCH-1:0] chan_on_r; // Channel enables
  logic [NCH-1:0] done_r; // Per-channel conversion done
  logic [NCH-1:0] ovr_r; // Per-channel overrun
  logic ready_r; // Latest result valid
  logic govr_r; // Global overrun
  logic cnt_end_r; // DMA count reached zero
  logic [31:0] irq_mask_r; // Interrupt mask state; no interrupt line in this block
  logic [CNT_W-1:0] dma_cnt_r; // DMA receive counter
  logic [CNT_W-1:0] dma_next_r; // DMA next receive counter
  logic [9:0] res_mem_r [NCH]; // Per-channel results
  logic [2:0] last_ch_r; // Channel of latest result
  logic [9:0] last_data_r; // Latest result
  adcsq_state_t st_r; // Sequencer state
  logic [8:0] tcnt_r; // Converter clock counter within a phase
  logic [2:0] cur_ch_r; // Channel being converted
  logic [31:0] rdata_nxt;
  logic conv_tick; // Converter clock tick
  logic hw_start; // Qualified hardware trigger edge

  // Soft reset pulse, held in its own flop so it also clears the rest
  always_ff @(posedge mclk) begin
    if (!rst_b) soft_rst_r <= 1'b0;
    else soft_rst_r <= soft_rst; // [R1]
  end

  adcsq_clkdiv #(.DIV_W(6)) u_div (
    .mclk(mclk),
    .rst_b(blk_rst_b),
    .divider(setup_r.conv_clock_divider),
    .tick(conv_tick)
  );

  adcsq_trigsel u_trig (
    .mclk(mclk),
    .rst_b(blk_rst_b),
    .timer_waveform_output(timer_waveform_output),
    .external_trigger_pin(external_trigger_pin),
    .enable(setup_r.hw_trigger_enable),
    .select(setup_r.hw_trigger_select),
    .hw_start(hw_start)
  );

  // Sequencer helper terms; triggers during a sequence are dropped
  wire start_req = sw_start || hw_start; // [R2] [R25]
  wire [8:0] wake_len = {{4{1'b0}}, setup_r.startup_time} * 9'(`ADCSQ_STARTUP_MULT * 2) + 9'h7;
  wire [NCH-1:0] above_mask = ~((NCH'(2) << cur_ch_r) - NCH'(1));
  wire [NCH-1:0] later_on = chan_on_r & above_mask;
  wire any_on = |chan_on_r;
  wire more_ch = |later_on;
  wire cell_ok = cell_done && st_r == ADCSQ_CONVERT;
  wire [9:0] res_val = setup_r.eight_bit_select ? {2'h0, cell_data[9:2]} : cell_data; // [R6]
  logic [2:0] first_ch;
  logic [2:0] next_ch;
  // Lowest enabled channel, and lowest enabled above the current one
  always_comb begin
    first_ch = '0;
    next_ch = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (chan_on_r[i]) first_ch = 3'(i);
      if (later_on[i]) next_ch = 3'(i);
    end
  end

  // Sequencer: wake, sample, convert per enabled channel, then idle
  always_ff @(posedge mclk) begin
    if (!blk_rst_b) begin
      st_r <= ADCSQ_IDLE;
      tcnt_r <= '0;
      cur_ch_r <= '0;
      warm_r <= 1'b0;
    end else begin
      case (st_r)
        ADCSQ_IDLE: begin
          if (start_req && any_on) begin
            st_r <= ADCSQ_WAKE;
            cur_ch_r <= first_ch;
            tcnt_r <= '0;
            // Power is judged at the start: it rises during wake and must not cut it short
            warm_r <= !setup_r.sleep_select && cell_power_on;
          end
        end
        ADCSQ_WAKE: begin
          // Cell already up in normal mode after first sequence: wake is short
          if (conv_tick) begin
            tcnt_r <= tcnt_r + 9'h1;
            if (tcnt_r >= wake_len || warm_r) begin // [R9]
              st_r <= ADCSQ_SAMPLE;
              tcnt_r <= '0;
            end
          end
        end
        ADCSQ_SAMPLE: begin
          if (conv_tick) begin
            tcnt_r <= tcnt_r + 9'h1;
            if (tcnt_r >= {5'h0, setup_r.sample_hold_time}) begin // [R10]
              st_r <= ADCSQ_CONVERT;
              tcnt_r <= '0;
            end
          end
        end
        ADCSQ_CONVERT: begin
          if (cell_ok) st_r <= ADCSQ_NEXT;
        end
        ADCSQ_NEXT: begin
          // Wait for a tick so the next sampling phase is whole converter periods
          if (more_ch && conv_tick) begin // [R10]
            cur_ch_r <= next_ch;
            st_r <= ADCSQ_SAMPLE;
          end else if (!more_ch) begin
            st_r <= ADCSQ_IDLE;
          end
        end
        default: st_r <= ADCSQ_IDLE;
      endcase
    end
  end

  // Cell control: power stays on in normal mode once woken, drops in sleep mode
  always_ff @(posedge mclk) begin
    if (!blk_rst_b) begin
      cell_power_on <= 1'b0;
      cell_convert <= 1'b0;
      cell_channel <= '0;
      cell_eight_bit <= 1'b0;
      cell_sampling <= 1'b0;
    end else begin
      if (st_r == ADCSQ_WAKE) cell_power_on <= 1'b1;
      else if (st_r == ADCSQ_IDLE && setup_r.sleep_select) cell_power_on <= 1'b0; // [R7]
      cell_convert <= st_r == ADCSQ_SAMPLE && conv_tick
                      && tcnt_r >= {5'h0, setup_r.sample_hold_time};
      cell_channel <= cur_ch_r;
      cell_eight_bit <= setup_r.eight_bit_select; // [R6]
      cell_sampling <= st_r == ADCSQ_SAMPLE;
    end
  end

  // Setup, channel enables and interrupt mask written by software
  always_ff @(posedge mclk) begin
    if (!blk_rst_b) begin
      setup_r <= '0;
      chan_on_r <= '0; // [R14]
      irq_mask_r <= '0;
    end else begin
      if (wr_setup) setup_r <= adcsq_setup_t'({reg_wdata[27:24], reg_wdata[20:16],
                                 reg_wdata[13:8], reg_wdata[5:0]}); // [R22]
      chan_on_r <= (chan_on_r | ({NCH{wr_chen}} & reg_wdata[NCH-1:0])) // [R11]
                   & ~({NCH{wr_chdis}} & reg_wdata[NCH-1:0]); // [R12]
      irq_mask_r <= (irq_mask_r | ({32{wr_unmask}} & reg_wdata & 32'h000fffff)) // [R26]
                    & ~({32{wr_remask}} & reg_wdata);
    end
  end

  // Per-channel results and flags; a hardware set wins over a read clear
  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    wire hit = cell_ok && cur_ch_r == 3'(g) && chan_on_r[g];
    wire clr = (rd_res && res_idx == 3'(g)) || (rd_latest && last_ch_r == 3'(g)); // [R23]
    always_ff @(posedge mclk) begin
      if (!blk_rst_b) begin
        res_mem_r[g] <= '0;
        done_r[g] <= 1'b0;
        ovr_r[g] <= 1'b0;
      end else begin
        if (hit) res_mem_r[g] <= res_val; // [R21]
        done_r[g] <= hit | (done_r[g] & ~clr); // [R15]
        ovr_r[g] <= (hit & done_r[g] & ~clr) | (ovr_r[g] & ~rd_flags); // [R16] [R24]
      end
    end
  end

  // Latest result, ready, global overrun and DMA counters
  always_ff @(posedge mclk) begin
    if (!blk_rst_b) begin
      last_ch_r <= '0;
      last_data_r <= '0;
      ready_r <= 1'b0;
      govr_r <= 1'b0;
      dma_cnt_r <= '0;
      dma_next_r <= '0;
      cnt_end_r <= 1'b1;
      dma_request <= 1'b0;
    end else begin
      if (cell_ok) begin
        last_ch_r <= cur_ch_r;
        last_data_r <= res_val;
      end
      ready_r <= cell_ok | (ready_r & ~rd_latest); // [R17] [R23]
      govr_r <= (cell_ok & ready_r & ~rd_latest) | (govr_r & ~rd_flags); // [R18] [R24]
      dma_request <= cell_ok && dma_cnt_r != '0;
      if (wr_dcnt) dma_cnt_r <= reg_wdata[CNT_W-1:0];
      else if (dma_word_taken && dma_cnt_r != '0) begin
        dma_cnt_r <= (dma_cnt_r == CNT_W'(1)) ? dma_next_r : dma_cnt_r - CNT_W'(1);
      end
      if (wr_dnext) dma_next_r <= reg_wdata[CNT_W-1:0];
      else if (!wr_dcnt && dma_word_taken && dma_cnt_r == CNT_W'(1)) dma_next_r <= '0;
      if (dma_word_taken && dma_cnt_r == CNT_W'(1)) cnt_end_r <= 1'b1; // [R19]
      else if (wr_dcnt || wr_dnext) cnt_end_r <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  wire buf_full = dma_cnt_r == '0 && dma_next_r == '0; // [R20]
  wire [31:0] flags_w = {12'h0, buf_full, cnt_end_r, govr_r, ready_r,
                         8'(ovr_r), 8'(done_r & chan_on_r)}; // [R15]
  always_comb begin
    rdata_nxt = '0;
    if (rd_res) rdata_nxt = {22'h0, res_mem_r[res_idx]};
    else begin
      case (reg_addr)
        `ADCSQ_OFF_SETUP: rdata_nxt = 32'(setup_r[5:0]) | (32'(setup_r[11:6]) << 8)
            | (32'(setup_r[16:12]) << 16) | (32'(setup_r[20:17]) << 24);
        `ADCSQ_OFF_CH_STATE: rdata_nxt = 32'(chan_on_r); // [R14]
        `ADCSQ_OFF_FLAGS: rdata_nxt = flags_w;
        `ADCSQ_OFF_LATEST: rdata_nxt = {22'h0, last_data_r};
        `ADCSQ_OFF_IRQ_STATE: rdata_nxt = irq_mask_r;
        `ADCSQ_OFF_DMA_CNT: rdata_nxt = 32'(dma_cnt_r);
        `ADCSQ_OFF_DMA_NEXT: rdata_nxt = 32'(dma_next_r);
        default: rdata_nxt = '0;
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (!rst_b) reg_rdata <= '0;
    else reg_rdata <= reg_rd ? rdata_nxt : '0;
  end

  a_soft_reset_clr: assert property (@(posedge mclk) disable iff (!rst_b)
    soft_rst |=> ##1 (chan_on_r == '0 && st_r == ADCSQ_IDLE)) // [R1]
    else $error("soft reset did not clear state");
  a_chen_sets: assert property (@(posedge mclk) disable iff (!blk_rst_b)
    wr_chen && !soft_rst |=> (chan_on_r & $past(reg_wdata[NCH-1:0])) != '0
      || $past(reg_wdata[NCH-1:0]) == '0 || $past(wr_chdis)) // [R11]
    else $error("channel enable ignored");
  a_chdis_clears: assert property (@(posedge mclk) disable iff (!blk_rst_b)
    wr_chdis |=> (chan_on_r & $past(reg_wdata[NCH-1:0])) == '0) // [R12]
    else $error("channel disable ignored");
  a_trig_off_idle: assert property (@(posedge mclk) disable iff (!blk_rst_b)
    st_r == ADCSQ_IDLE && !sw_start && !setup_r.hw_trigger_enable
      && !$past(setup_r.hw_trigger_enable) |=> st_r == ADCSQ_IDLE) // [R3]
    else $error("sequence started without trigger");
  a_start_wakes: assert property (@(posedge mclk) disable iff (!blk_rst_b)
    st_r == ADCSQ_IDLE && sw_start && any_on && !soft_rst |=> st_r == ADCSQ_WAKE) // [R2]
    else $error("start did not begin sequence");
  a_wake_full: assert property (@(posedge mclk) disable iff (!blk_rst_b)
    st_r == ADCSQ_WAKE && !warm_r && conv_tick && tcnt_r < wake_len |=> st_r == ADCSQ_WAKE) // [R9]
    else $error("startup wait cut short");
  a_ovr_status_clr: assert property (@(posedge mclk) disable iff (!blk_rst_b)
    rd_flags && !cell_ok |=> ovr_r == '0 && !govr_r) // [R24]
    else $error("status read left overruns");
  a_ready_sets: assert property (@(posedge mclk) disable iff (!blk_rst_b)
    cell_ok |=> ready_r) // [R17]
    else $error("ready not set by result");
  a_buf_full: assert property (@(posedge mclk) disable iff (!blk_rst_b)
    reg_rd && reg_addr == `ADCSQ_OFF_FLAGS |=> reg_rdata[19] == $past(buf_full)) // [R20]
    else $error("buffer full flag wrong");
  a_tick_period: assert property (@(posedge mclk) disable iff (!blk_rst_b)
    conv_tick && setup_r.conv_clock_divider == '0 ##1 setup_r.conv_clock_divider == '0
      |=> conv_tick) // [R8]
    else $error("converter clock period wrong");
  c_sequence: cover property (@(posedge mclk) st_r == ADCSQ_NEXT && !more_ch);
  c_hw_start: cover property (@(posedge mclk) hw_start && st_r == ADCSQ_IDLE);
  c_overrun: cover property (@(posedge mclk) govr_r && ovr_r != '0);
endmodule : adcsq_top

// >>> src/adcsq_trigsel.sv
// Hardware trigger selection with two-stage synchronisers and rising-edge detect.
// Assumes trigger pins are asynchronous to mclk.
`timescale 1ns/100ps
`include "adcsq_regs.svh"
module adcsq_trigsel
  import adcsq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] timer_waveform_output,
  input wire logic external_trigger_pin,
  input wire logic enable,
  input wire logic [2:0] select,
  output logic hw_start
);
  logic [3:0] meta_r; // First synchroniser stage, read only by sync_r
  logic [3:0] sync_r; // Second synchroniser stage
  logic prev_r; // Selected level one cycle ago
  logic sel_lvl;
  // Reserved codes pick nothing, so they never start a sequence
  always_comb begin
    case (select)
      `ADCSQ_SEL_TIMER0: sel_lvl = sync_r[0]; // [R5]
      `ADCSQ_SEL_TIMER1: sel_lvl = sync_r[1]; // [R5]
      `ADCSQ_SEL_TIMER2: sel_lvl = sync_r[2]; // [R5]
      `ADCSQ_SEL_EXT: sel_lvl = sync_r[3]; // [R5]
      default: sel_lvl = 1'b0;
    endcase
  end
  // Synchronise, then fire on a rising edge only while enabled
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= 1'b0;
      hw_start <= 1'b0;
    end else begin
      meta_r <= {external_trigger_pin, timer_waveform_output};
      sync_r <= meta_r;
      prev_r <= sel_lvl;
      hw_start <= enable & sel_lvl & ~prev_r; // [R3] [R4] [R25]
    end
  end
endmodule : adcsq_trigsel
